// [rtl/pli_parallel_line.sv]
// Output stream FIFO and the parallel line port top module
`default_nettype none

module pli_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clr,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];  // Storage array
  logic [AW:0] wr_ptr;  // Write pointer with wrap bit
  logic [AW:0] rd_ptr;  // Read pointer with wrap bit
  logic full;
  logic empty;

  assign empty = (wr_ptr == rd_ptr);
  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr[AW-1:0]];

  // Storage write
  always_ff @(posedge clk)
  begin
    if (in_valid && !full)
    begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  // Pointer update
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else if (clr)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (in_valid && !full)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_ready && !empty)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule : pli_fifo

module pli_parallel_line #(
  parameter logic [15:0] DEV_BASE = 16'he800,  // Jumper base; arbitrary default
  parameter logic [15:0] VECTOR_A = 16'h0100,  // Vector A; arbitrary default
  parameter logic [15:0] VECTOR_B = 16'h0104,  // Vector B; arbitrary default
  parameter int REPLY_DELAY = 0,  // Reply hold-off in cycles, stretches pulses
  parameter int DEPTH = pli_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // Processor bus, active low strobes
  input wire logic ADDRESS_SYNC_N,
  input wire logic BUS_INPUT_STROBE_N,
  input wire logic BUS_OUTPUT_STROBE_N,
  input wire logic WRITE_BYTE_FLAG_N,
  input wire logic IRQ_ACK_IN_N,
  input wire logic BUS_INITIALIZE_N,
  output logic BUS_REPLY_N,
  output logic BUS_IRQ_N,
  output logic IRQ_ACK_OUT_N,
  // Multiplexed address/data lines, three-signal pin
  input wire logic [15:0] BUS_ADDR_DATA_IN,
  output logic [15:0] BUS_ADDR_DATA_OUT,
  output logic BUS_ADDR_DATA_OE_N,
  // User device side
  input wire logic [15:0] DEVICE_INPUT_LINES,
  output logic [15:0] DEVICE_OUTPUT_LINES,
  output logic NEW_DATA_READY,
  output logic DATA_TRANSMITTED_PULSE,
  input wire logic REQ_A,
  input wire logic REQ_B,
  output logic USER_BIT_0,
  output logic USER_BIT_1,
  output logic INIT_OUT_A,
  output logic INIT_OUT_B_N,
  input wire logic MAINT_LOOPBACK,
  // Output word stream
  output logic STREAM_VALID,
  input wire logic STREAM_READY,
  output logic [15:0] STREAM_DATA
);
  localparam int NS = 41;  // Width of the synchronised pin bundle
  localparam logic [pli_pkg::DELAY_W-1:0] DELAY_CYC = pli_pkg::DELAY_W'(REPLY_DELAY);

  // Synchroniser stages; stage 0 feeds only stage 1
  logic [NS-1:0] sync_stage [pli_pkg::SYNC_STAGES];
  logic [NS-1:0] pins;
  logic sync_a, din_a, dout_a, wtbt_a, iaki_a, init_a, req_a_pin, req_b_pin, maint;
  logic [15:0] dal;  // Synchronised address/data
  logic [15:0] dev_in;  // Synchronised device input
  logic sync_prev;  // Delayed sync for edge detect
  logic sync_rise;
  logic addr_hit;
  logic device_selected;  // Set on sync leading edge
  logic [2:0] addr_lo;  // Captured address bits 0-2
  logic [15:0] output_buffer;
  logic user_bit_0, user_bit_1, irq_enable_a, irq_enable_b;
  logic req_a_eff, req_b_eff, pend_a, pend_b;
  logic vec_phase;  // Vector being returned
  logic vec_is_b;  // Which vector is returned
  logic pass_ack;  // Acknowledge passed downstream
  logic wr_done;  // Write of this strobe completed
  logic [pli_pkg::DELAY_W-1:0] delay_cnt;
  logic delay_ok;
  logic sel_csr, sel_obuf, sel_inp;
  logic do_write;
  logic fifo_in_ready;
  logic reply_ok;
  logic [15:0] next_output_buffer;
  logic [15:0] read_data;
  logic [15:0] input_port;

  assign pins = {BUS_ADDR_DATA_IN, DEVICE_INPUT_LINES, ~ADDRESS_SYNC_N, ~BUS_INPUT_STROBE_N,
                 ~BUS_OUTPUT_STROBE_N, ~WRITE_BYTE_FLAG_N, ~IRQ_ACK_IN_N, ~BUS_INITIALIZE_N,
                 REQ_A, REQ_B, MAINT_LOOPBACK};

  // Two-flop synchroniser chain for every pin input
  generate
    for (genvar i = 0; i < pli_pkg::SYNC_STAGES; i++)
    begin : g_sync
      always_ff @(posedge CLK or negedge ARST_N)
      begin
        if (!ARST_N)
        begin
          sync_stage[i] <= '0;
        end
        else
        begin
          sync_stage[i] <= (i == 0) ? pins : sync_stage[(i == 0) ? 0 : i - 1];
        end
      end
    end
  endgenerate

  assign {dal, dev_in, sync_a, din_a, dout_a, wtbt_a, iaki_a, init_a, req_a_pin, req_b_pin,
          maint} = sync_stage[pli_pkg::SYNC_STAGES-1];

  // Register picked by a captured offset
  function automatic logic hits(input logic [2:0] lo, input logic [2:0] ofs);
    hits = (lo[2:1] == ofs[2:1]);
  endfunction : hits

  assign sync_rise = sync_a && !sync_prev;
  assign addr_hit = (dal[15:13] == pli_pkg::UPPER_WINDOW)
                    && (dal[12:3] == DEV_BASE[12:3]);
  assign sel_csr = device_selected && hits(addr_lo, pli_pkg::OFS_CONTROL_STATUS);
  assign sel_obuf = device_selected && hits(addr_lo, pli_pkg::OFS_OUTPUT_BUFFER);
  assign sel_inp = device_selected && hits(addr_lo, pli_pkg::OFS_INPUT_PORT);
  assign delay_ok = (delay_cnt >= DELAY_CYC);
  // A full stream buffer holds the write and therefore the reply
  assign do_write = device_selected && dout_a && !wr_done && delay_ok
                    && (!sel_obuf || fifo_in_ready);
  assign reply_ok = ((device_selected && ((dout_a && wr_done) || (din_a && delay_ok)))
                    || (vec_phase && din_a && delay_ok)) && !init_a;

  // Loopback feeds user bits into the request inputs
  assign req_a_eff = maint ? user_bit_0 : req_a_pin;
  assign req_b_eff = maint ? user_bit_1 : req_b_pin;
  assign pend_a = irq_enable_a && req_a_eff;
  assign pend_b = irq_enable_b && req_b_eff;
  assign input_port = maint ? output_buffer : dev_in;

  // Byte lanes of the output buffer
  always_comb
  begin
    next_output_buffer = output_buffer;
    if (!wtbt_a)
    begin
      next_output_buffer = dal;
    end
    else if (addr_lo[0])
    begin
      next_output_buffer[15:8] = dal[15:8];
    end
    else
    begin
      next_output_buffer[7:0] = dal[7:0];
    end
  end

  // Read multiplexer
  always_comb
  begin
    read_data = '0;
    if (vec_phase)
    begin
      read_data = vec_is_b ? VECTOR_B : VECTOR_A;
    end
    else if (sel_csr)
    begin
      read_data[pli_pkg::BIT_REQ_B] = req_b_eff;
      read_data[pli_pkg::BIT_REQ_A] = req_a_eff;
      read_data[pli_pkg::BIT_IRQ_ENABLE_A] = irq_enable_a;
      read_data[pli_pkg::BIT_IRQ_ENABLE_B] = irq_enable_b;
      read_data[pli_pkg::BIT_USER_1] = user_bit_1;
      read_data[pli_pkg::BIT_USER_0] = user_bit_0;
    end
    else if (sel_obuf)
    begin
      read_data = output_buffer;
    end
    else if (sel_inp)
    begin
      read_data = input_port;
    end
  end

  // Device select flag and captured offset
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      sync_prev <= 1'b0;
      device_selected <= 1'b0;
      addr_lo <= '0;
    end
    else
    begin
      sync_prev <= sync_a;
      if (sync_rise)
      begin
        device_selected <= addr_hit && !init_a;
        addr_lo <= dal[2:0];
      end
      else if (!sync_a || init_a)
      begin
        device_selected <= 1'b0;
      end
    end
  end

  // Write completion and reply hold-off counter
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      wr_done <= 1'b0;
      delay_cnt <= '0;
    end
    else
    begin
      if (!dout_a)
      begin
        wr_done <= 1'b0;
      end
      else if (do_write)
      begin
        wr_done <= 1'b1;
      end
      if ((din_a || dout_a) && (device_selected || vec_phase))
      begin
        if (!delay_ok)
        begin
          delay_cnt <= delay_cnt + 1'b1;
        end
      end
      else
      begin
        delay_cnt <= '0;
      end
    end
  end

  // Output buffer latches
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      output_buffer <= pli_pkg::OUTPUT_BUFFER_RESET;
    end
    else if (init_a)
    begin
      output_buffer <= pli_pkg::OUTPUT_BUFFER_RESET;
    end
    else if (do_write && sel_obuf)
    begin
      output_buffer <= next_output_buffer;
    end
  end

  // Control/status writable bits; only the low byte holds any
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      user_bit_0 <= pli_pkg::CONTROL_BIT_RESET;
      user_bit_1 <= pli_pkg::CONTROL_BIT_RESET;
      irq_enable_a <= pli_pkg::CONTROL_BIT_RESET;
      irq_enable_b <= pli_pkg::CONTROL_BIT_RESET;
    end
    else if (init_a)
    begin
      user_bit_0 <= pli_pkg::CONTROL_BIT_RESET;
      user_bit_1 <= pli_pkg::CONTROL_BIT_RESET;
      irq_enable_a <= pli_pkg::CONTROL_BIT_RESET;
      irq_enable_b <= pli_pkg::CONTROL_BIT_RESET;
    end
    else if (do_write && sel_csr && !(wtbt_a && addr_lo[0]))
    begin
      user_bit_0 <= dal[pli_pkg::BIT_USER_0];
      user_bit_1 <= dal[pli_pkg::BIT_USER_1];
      irq_enable_a <= dal[pli_pkg::BIT_IRQ_ENABLE_A];
      irq_enable_b <= dal[pli_pkg::BIT_IRQ_ENABLE_B];
    end
  end

  // Interrupt acknowledge: serve A first, else pass down
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      vec_phase <= 1'b0;
      vec_is_b <= 1'b0;
      pass_ack <= 1'b0;
    end
    else if (init_a || !iaki_a)
    begin
      vec_phase <= 1'b0;
      pass_ack <= 1'b0;
    end
    else if (!vec_phase && !pass_ack)
    begin
      if (!pend_a && !pend_b)
      begin
        pass_ack <= 1'b1;
      end
      else if (din_a)
      begin
        vec_phase <= 1'b1;
        vec_is_b <= !pend_a;
      end
    end
  end

  // Registered bus-side outputs
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      BUS_REPLY_N <= 1'b1;
      BUS_IRQ_N <= 1'b1;
      IRQ_ACK_OUT_N <= 1'b1;
      BUS_ADDR_DATA_OUT <= '0;
      BUS_ADDR_DATA_OE_N <= 1'b1;
    end
    else
    begin
      BUS_REPLY_N <= !reply_ok;
      BUS_IRQ_N <= !((pend_a || pend_b) && !vec_phase && !init_a);
      IRQ_ACK_OUT_N <= !(pass_ack && iaki_a);
      BUS_ADDR_DATA_OUT <= read_data;
      BUS_ADDR_DATA_OE_N <= !(din_a && (device_selected || vec_phase) && !init_a);
    end
  end

  // Registered device-side outputs
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      NEW_DATA_READY <= 1'b0;
      DATA_TRANSMITTED_PULSE <= 1'b0;
      INIT_OUT_A <= 1'b0;
      INIT_OUT_B_N <= 1'b1;
    end
    else
    begin
      NEW_DATA_READY <= sel_obuf && dout_a;
      DATA_TRANSMITTED_PULSE <= sel_inp && din_a;
      INIT_OUT_A <= init_a;
      INIT_OUT_B_N <= !init_a;
    end
  end

  assign DEVICE_OUTPUT_LINES = output_buffer;
  assign USER_BIT_0 = user_bit_0;
  assign USER_BIT_1 = user_bit_1;

  // Every written buffer value also enters the stream; an initialize clear does not
  pli_fifo #(
    .WIDTH(16),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(CLK),
    .arst_n(ARST_N),
    .clr(init_a),
    .in_valid(do_write && sel_obuf),
    .in_ready(fifo_in_ready),
    .in_data(next_output_buffer),
    .out_valid(STREAM_VALID),
    .out_ready(STREAM_READY),
    .out_data(STREAM_DATA)
  );

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  property p_select;
    sync_rise && addr_hit && !init_a |=> device_selected && addr_lo == $past(dal[2:0]);
  endproperty
  a_select: assert property (p_select) else $error("select not captured");
  property p_reply;
    (device_selected && din_a && delay_ok && !init_a) |=> !BUS_REPLY_N;
  endproperty
  a_reply: assert property (p_reply) else $error("no reply to input strobe");
  property p_reply_drop;
    !din_a && !dout_a |=> BUS_REPLY_N;
  endproperty
  a_reply_drop: assert property (p_reply_drop) else $error("reply without strobe");
  property p_ndr;
    sel_obuf && dout_a |=> NEW_DATA_READY;
  endproperty
  a_ndr: assert property (p_ndr) else $error("new-data-ready missing");
  property p_dtr;
    sel_inp && din_a |=> DATA_TRANSMITTED_PULSE ##1 (DATA_TRANSMITTED_PULSE || !din_a);
  endproperty
  a_dtr: assert property (p_dtr) else $error("data-transmitted broken");
  property p_byte_low;
    do_write && sel_obuf && wtbt_a && !addr_lo[0] && !init_a
      |=> output_buffer[15:8] == $past(output_buffer[15:8]);
  endproperty
  a_byte_low: assert property (p_byte_low) else $error("high byte disturbed");
  property p_status;
    sel_csr && din_a && !vec_phase
      |=> BUS_ADDR_DATA_OUT[7] == $past(req_a_eff) && BUS_ADDR_DATA_OUT[15] == $past(req_b_eff);
  endproperty
  a_status: assert property (p_status) else $error("request bits wrong");
  property p_irq;
    pend_a && !vec_phase && !init_a |=> !BUS_IRQ_N;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");
  property p_prio;
    iaki_a && din_a && !vec_phase && !pass_ack && pend_a && !init_a |=> vec_phase && !vec_is_b;
  endproperty
  a_prio: assert property (p_prio) else $error("request A not first");
  property p_loop;
    maint && sel_inp && din_a && !vec_phase |=> BUS_ADDR_DATA_OUT == $past(output_buffer);
  endproperty
  a_loop: assert property (p_loop) else $error("loopback data wrong");
  property p_init;
    init_a |=> output_buffer == '0 && !irq_enable_a && !user_bit_0 && INIT_OUT_A && !INIT_OUT_B_N;
  endproperty
  a_init: assert property (p_init) else $error("initialize incomplete");
  property p_delay;
    delay_cnt <= pli_pkg::DELAY_W'(pli_pkg::MAX_PULSE_CYC);
  endproperty
  a_delay: assert property (p_delay) else $error("reply delay too long");

  c_word_write: cover property (do_write && sel_obuf && !wtbt_a);
  c_input_read: cover property (DATA_TRANSMITTED_PULSE && !BUS_REPLY_N);
  c_vector_b: cover property (vec_phase && vec_is_b && !BUS_REPLY_N);
  c_pass: cover property (!IRQ_ACK_OUT_N);
endmodule : pli_parallel_line
`default_nettype wire

// [rtl/pli_pkg.sv]
// Package with offsets, field positions, reset values and timing counts of the parallel line port
`default_nettype none
package pli_pkg;
  // Register offsets within the device window
  localparam logic [2:0] OFS_CONTROL_STATUS = 3'h0;
  localparam logic [2:0] OFS_OUTPUT_BUFFER = 3'h2;
  localparam logic [2:0] OFS_INPUT_PORT = 3'h4;
  // Control/status field positions
  localparam int BIT_USER_0 = 0;
  localparam int BIT_USER_1 = 1;
  localparam int BIT_IRQ_ENABLE_B = 5;
  localparam int BIT_IRQ_ENABLE_A = 6;
  localparam int BIT_REQ_A = 7;
  localparam int BIT_REQ_B = 15;
  // Reset values
  localparam logic [15:0] OUTPUT_BUFFER_RESET = 16'h0000;
  localparam logic CONTROL_BIT_RESET = 1'b0;
  // Upper 8K window: top three byte-address bits set
  localparam logic [2:0] UPPER_WINDOW = 3'h7;
  // Depth of the pin synchroniser
  localparam int SYNC_STAGES = 2;
  // Clock and pulse timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int NOMINAL_PULSE_NS = 300;
  localparam int MAX_PULSE_NS = 1200;
  localparam int MAX_PULSE_CYC = MAX_PULSE_NS / CLK_PERIOD_NS;
  // Width of the reply delay counter
  localparam int DELAY_W = 8;
  // Default depth of the output stream buffer
  localparam int FIFO_DEPTH = 16;
endpackage : pli_pkg
`default_nettype wire

// [bench/pli_bus_master.sv]
// Processor-side bus master model for the parallel line port
`default_nettype none
module pli_bus_master (
  // Clock
  input wire logic clk,
  // Bus controls, active low
  output logic sync_n,
  output logic din_n,
  output logic dout_n,
  output logic wtbt_n,
  output logic iak_n,
  output logic init_n,
  input wire logic reply_n,
  // Address/data: what we drive, and the resolved wire
  output logic [15:0] drv,
  input wire logic [15:0] wire_lines
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle bus at time zero
  initial
  begin
    {sync_n, din_n, dout_n, wtbt_n, iak_n, init_n} = 6'h3f;
    drv = 16'h0000;
  end
  // Move to just after a later rising edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  // Reply sampled at an edge, bounded so a dead port cannot hang us
  task automatic wait_reply(output logic ok);
    int i;
    ok = 1'b0;
    for (i = 0; i < 300 && !ok; i++)
    begin
      @(posedge clk);
      ok = (reply_n === 1'b0);
    end
  endtask : wait_reply
  // One programmed cycle: address phase, then one read or write strobe
  task automatic xfer(input logic [15:0] a, input logic wr, input logic bt,
                      input logic [15:0] d, output logic [15:0] q, output logic ok);
    int i;
    drv = a;
    sync_n = 1'b0;
    step(4);
    // Released lines show the inverse, never a stale address
    drv = wr ? d : ~a;
    wtbt_n = ~(wr & bt);
    dout_n = ~wr;
    din_n = wr;
    wait_reply(ok);
    q = wire_lines;
    #1;
    {din_n, dout_n, wtbt_n} = 3'h7;
    drv = ~drv;
    // Hold sync until the reply is withdrawn
    for (i = 0; i < 40 && reply_n === 1'b0; i++)
      step(1);
    sync_n = 1'b1;
    step(3);
  endtask : xfer
  // Interrupt acknowledge cycle: input strobe, then acknowledge
  task automatic vec(output logic [15:0] q, output logic ok);
    din_n = 1'b0;
    drv = ~drv;
    step(1);
    iak_n = 1'b0;
    wait_reply(ok);
    q = wire_lines;
    #1;
    din_n = 1'b1;
    iak_n = 1'b1;
    step(4);
  endtask : vec
  // Bus initialize held for n cycles
  task automatic init_pulse(input int n);
    init_n = 1'b0;
    step(n);
    init_n = 1'b1;
    step(4);
  endtask : init_pulse
endmodule : pli_bus_master
`default_nettype wire

// [bench/pli_parallel_line_tb.sv]
// Self-checking bench for the parallel line port
`default_nettype none
module pli_parallel_line_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DLY = 10;  // Reply hold-off, stretches pulses
  localparam logic [15:0] BASE = 16'he800;  // Device window base, default jumpers
  localparam logic [15:0] VA = 16'h0100;  // Vector A, default jumpers
  localparam logic [15:0] VB = 16'h0104;  // Vector B, default jumpers
  // Clock, reset and bus
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic sync_n, din_n, dout_n, wtbt_n, iak_n, init_n, reply_n, irq_n, ack_out_n, oe_n;
  logic [15:0] drv, bus_out, bus_wire, dev_in, dev_out, s_data, taken, buf_exp;
  // User side
  logic ndr, dtp, req_a, req_b, ub0, ub1, init_a, init_b_n, loop, s_valid, s_ready;
  logic ndr_d, dtp_d;
  // Scoreboard and pulse statistics
  int fails = 0;
  int total_checks = 0;
  int ndr_n = 0, dtp_n = 0, ndr_len = 0, dtp_len = 0, dtp_w = 0, ndr_w = 0;
  int ack_cyc = 0, init_cyc = 0;
  logic [15:0] exp_q[$];
  always #4 clk = ~clk;
  // The port wins the wire while it drives
  assign bus_wire = (oe_n === 1'b0) ? bus_out : drv;
  pli_parallel_line #(.REPLY_DELAY(DLY))
    pli_parallel_line_i (.CLK(clk), .ARST_N(arst_n), .ADDRESS_SYNC_N(sync_n),
    .BUS_INPUT_STROBE_N(din_n), .BUS_OUTPUT_STROBE_N(dout_n), .WRITE_BYTE_FLAG_N(wtbt_n),
    .IRQ_ACK_IN_N(iak_n), .BUS_INITIALIZE_N(init_n), .BUS_REPLY_N(reply_n),
    .BUS_IRQ_N(irq_n), .IRQ_ACK_OUT_N(ack_out_n), .BUS_ADDR_DATA_IN(bus_wire),
    .BUS_ADDR_DATA_OUT(bus_out), .BUS_ADDR_DATA_OE_N(oe_n), .DEVICE_INPUT_LINES(dev_in),
    .DEVICE_OUTPUT_LINES(dev_out), .NEW_DATA_READY(ndr), .DATA_TRANSMITTED_PULSE(dtp),
    .REQ_A(req_a), .REQ_B(req_b), .USER_BIT_0(ub0), .USER_BIT_1(ub1), .INIT_OUT_A(init_a),
    .INIT_OUT_B_N(init_b_n), .MAINT_LOOPBACK(loop), .STREAM_VALID(s_valid),
    .STREAM_READY(s_ready), .STREAM_DATA(s_data));
  pli_bus_master pli_bus_master_i (.clk(clk), .sync_n(sync_n), .din_n(din_n),
    .dout_n(dout_n), .wtbt_n(wtbt_n), .iak_n(iak_n), .init_n(init_n), .reply_n(reply_n),
    .drv(drv), .wire_lines(bus_wire));
  // Compare one value
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // User device watcher: pulse counts, output word taking, stream drain
  always @(posedge clk)
  begin
    if (ndr === 1'b1)
      ndr_len++;
    if (dtp === 1'b1)
      dtp_len++;
    // Output word taken at the trailing edge
    if (ndr !== 1'b1 && ndr_d === 1'b1)
    begin
      taken = dev_out;
      ndr_w = ndr_len;
      ndr_n++;
      ndr_len = 0;
    end
    if (dtp !== 1'b1 && dtp_d === 1'b1)
    begin
      dtp_w = dtp_len;
      dtp_n++;
      dtp_len = 0;
    end
    if (s_valid === 1'b1 && s_ready === 1'b1)
      chk(s_data, exp_q.pop_front());
    if (ack_out_n === 1'b0)
      ack_cyc++;
    if (init_a === 1'b1 && init_b_n === 1'b0)
      init_cyc++;
    ndr_d = ndr;
    dtp_d = dtp;
  end
  // Programmed write; buffer writes also tracked for the stream
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic bt);
    logic [15:0] q;
    logic ok;
    int n;
    n = ndr_n;
    if (a == BASE + 16'h2)
      buf_exp = bt ? {buf_exp[15:8], d[7:0]} : d;
    if (a == BASE + 16'h3)
      buf_exp = {d[15:8], buf_exp[7:0]};
    if (a[15:1] == BASE[15:1] + 15'h1)
      exp_q.push_back(buf_exp);
    pli_bus_master_i.xfer(a, 1'b1, bt, d, q, ok);
    chk({15'h0, ok}, 16'h1);
    if (a[15:1] == BASE[15:1] + 15'h1)
    begin
      chk(16'(ndr_n - n), 16'h1);
      chk(16'(ndr_w > DLY), 16'h1);
      chk(taken, buf_exp);
      chk(dev_out, buf_exp);
    end
  endtask : wr
  // Programmed read; input port reads also pulse data-transmitted
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] q;
    logic ok;
    int n;
    n = dtp_n;
    pli_bus_master_i.xfer(a, 1'b0, 1'b0, 16'h0000, q, ok);
    chk({15'h0, ok}, 16'h1);
    chk(q, exp);
    chk(16'(dtp_n - n), {15'h0, a == BASE + 16'h4});
    if (a == BASE + 16'h4)
      chk(16'(dtp_w > DLY), 16'h1);
  endtask : rd
  // Address outside the window: no reply at all
  task automatic nosel(input logic [15:0] a);
    logic [15:0] q;
    logic ok;
    pli_bus_master_i.xfer(a, 1'b0, 1'b0, 16'h0000, q, ok);
    chk({15'h0, ok}, 16'h0);
  endtask : nosel
  // Vector cycle, expecting a given vector
  task automatic vec(input logic [15:0] exp);
    logic [15:0] q;
    logic ok;
    pli_bus_master_i.vec(q, ok);
    chk({15'h0, ok}, 16'h1);
    chk(q, exp);
  endtask : vec
  // Reset state and address decoding
  task automatic t_decode();
    chk({dev_out[15:2], ub1, ub0}, 16'h0000);
    rd(BASE, 16'h0000);
    rd(BASE + 16'h6, 16'h0000);
    nosel(BASE + 16'h0010);
    nosel(16'h6800);
  endtask : t_decode
  // Word and byte writes to the output buffer
  task automatic t_buffer();
    wr(BASE + 16'h2, 16'ha55a, 1'b0);
    rd(BASE + 16'h2, 16'ha55a);
    wr(BASE + 16'h2, 16'h77c3, 1'b1);
    wr(BASE + 16'h3, 16'h96ff, 1'b1);
    rd(BASE + 16'h2, 16'h96c3);
  endtask : t_buffer
  // Input port read; each read follows the new lines and pulses data-transmitted
  task automatic t_input();
    dev_in = 16'h8421;
    rd(BASE + 16'h4, 16'h8421);
    dev_in = 16'h7bde;
    rd(BASE + 16'h4, 16'h7bde);
  endtask : t_input
  // Control bits, read-only request bits and interrupts
  task automatic t_csr_irq();
    logic [15:0] q;
    logic ok;
    wr(BASE, 16'hffff, 1'b0);
    rd(BASE, 16'h0063);
    chk({14'h0, ub1, ub0}, 16'h0003);
    wr(BASE + 16'h1, 16'h0000, 1'b1);
    rd(BASE, 16'h0063);
    req_a = 1'b1;
    req_b = 1'b1;
    pli_bus_master_i.step(6);
    chk({15'h0, irq_n}, 16'h0000);
    rd(BASE, 16'h80e3);
    vec(VA);
    req_a = 1'b0;
    pli_bus_master_i.step(6);
    vec(VB);
    req_b = 1'b0;
    pli_bus_master_i.step(6);
    chk({15'h0, irq_n}, 16'h0001);
    wr(BASE, 16'h0000, 1'b0);
    req_a = 1'b1;
    pli_bus_master_i.step(6);
    chk({15'h0, irq_n}, 16'h0001);
    req_a = 1'b0;
    ack_cyc = 0;
    pli_bus_master_i.vec(q, ok);
    chk({15'h0, ok}, 16'h0000);
    chk(16'(ack_cyc > 0), 16'h1);
  endtask : t_csr_irq
  // Fill the stream buffer until writes stall, then drain it
  task automatic t_fifo();
    int i;
    s_ready = 1'b0;
    for (i = 0; i < 16; i++)
      wr(BASE + 16'h2, 16'(i * 16'h1111 + 16'h0f), 1'b0);
    fork
      wr(BASE + 16'h2, 16'hbeef, 1'b0);
      begin
        pli_bus_master_i.step(60);
        chk({15'h0, reply_n}, 16'h0001);
        s_ready = 1'b1;
      end
    join
    // Seventeen words drain one per cycle after the stall lifts
    pli_bus_master_i.step(16);
    chk(16'(exp_q.size()), 16'h0000);
  endtask : t_fifo
  // Loopback: input port reads the buffer, user bit 1 drives request B
  task automatic t_loop();
    loop = 1'b1;
    wr(BASE + 16'h2, 16'h5aa5, 1'b0);
    rd(BASE + 16'h4, 16'h5aa5);
    wr(BASE, 16'h0022, 1'b0);
    pli_bus_master_i.step(6);
    chk({15'h0, irq_n}, 16'h0000);
    rd(BASE, 16'h8022);
    vec(VB);
    wr(BASE, 16'h0000, 1'b0);
    loop = 1'b0;
  endtask : t_loop
  // Initialize clears state and is forwarded on both lines
  task automatic t_init();
    wr(BASE, 16'h0063, 1'b0);
    s_ready = 1'b0;
    wr(BASE + 16'h2, 16'h4321, 1'b0);
    init_cyc = 0;
    pli_bus_master_i.init_pulse(8);
    chk(16'(init_cyc), 16'h0008);
    chk({dev_out[15:2], ub1, ub0}, 16'h0000);
    chk({15'h0, s_valid}, 16'h0000);
    exp_q.delete();
    buf_exp = 16'h0000;
    s_ready = 1'b1;
    rd(BASE, 16'h0000);
    rd(BASE + 16'h2, 16'h0000);
  endtask : t_init
  // Verdict and end of run
  task automatic test_done();
    if (fails == 0 && total_checks > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  // Watchdog against a hung bus
  initial
  begin
    #400000;
    fails++;
    test_done();
  end
  // Main sequence
  initial
  begin
    {req_a, req_b, loop, s_ready, ndr_d, dtp_d} = 6'h04;
    dev_in = 16'h0000;
    buf_exp = 16'h0000;
    repeat (6) @(posedge clk);
    #1;
    arst_n = 1'b1;
    pli_bus_master_i.step(2);
    t_decode();
    t_buffer();
    t_input();
    t_csr_irq();
    t_fifo();
    t_loop();
    t_init();
    test_done();
  end
endmodule : pli_parallel_line_tb
`default_nettype wire
